/* File: rtl/rsc_radio_ctrl.v */
// Radio state command controller: decodes commands and sequences the radio.
// Behaviour
// - Chip-select low in sleep wakes into off; ready flag then rises.
// - A chip-select wake is not flagged as power-on reset.
// - Timer wake with smart wake set runs the smart wake routine.
// - Timer wake without smart wake or firmware timer lands in off.
// - Go-off in on state enters off and drops RF regulators.
// - Go-on from off powers regulators, filter-calibrates only if enabled.
// - Go-on from transmit ramps PA down, drops PA, stops tx, synth off.
// - Go-on from receive copies strength, drops LNA, powers receive down.
// - Go-sleep from off or on enters sleep, keeping config RAM.
// - Receive from on powers synth and rx, sets channel, settles.
// - Receive while receiving drops LNA, unlocks loops, redoes setup.
// - Receive from transmit ramps PA down, stops tx, then sets up rx.
// - Transmit from on powers synth, sets up, ramps PA, sends data.
// - Transmit while transmitting ramps down, stops tx, redoes setup.
// - Transmit from receive stops rx and skips oscillator calibration.
// - Channel frequency is loaded only by transmit and receive.
// - Configure in off or on loads all parameters from config RAM.
// - Measure in on state powers receiver, stores strength, returns on.
// - Filter calibrate runs only in the on state.
// - Hardware reset works in any state and enters sleep.
// - Load-done in off after load-prepare resets processor and packets.
// - Image calibrate runs only once firmware was loaded.
// - A command byte acts on its last rising serial clock edge.
`timescale 1ns/100ps
`include "rsc_defines.vh"
module rsc_radio_ctrl #(
  parameter STEP = 8,
  parameter SETTLE = 64
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        sclk,
  input  wire        csN,
  input  wire        mosi,
  output wire        misoOut,
  output wire        misoOeN,
  input  wire        wakeTimeout,
  input  wire        smartWakeEn,
  input  wire        fwTimerEn,
  input  wire [9:0]  regAddr,
  input  wire [7:0]  regWdata,
  input  wire        regWrite,
  output reg  [7:0]  regRdata,
  input  wire [7:0]  strengthMeas,
  input  wire [23:0] channelFreqCfg,
  output reg  [4:0]  recordedRadioState,
  output reg         cmdReady,
  output reg         powerOnResetFlag,
  output reg         rfRegulatorOn,
  output reg         synthOn,
  output reg         receiverOn,
  output reg         rxLogicOn,
  output reg         txLogicOn,
  output reg         paOn,
  output reg         extPaOn,
  output reg         extLnaOn,
  output reg         loopsLocked,
  output reg  [23:0] channelFreq,
  output reg         configPulse,
  output reg         calPulse,
  output reg         smartWakePulse,
  output reg         procResetPulse,
  output reg         packetClearPulse
);
  localparam [4:0] ST_SLEEP = 5'h01;
  localparam [4:0] ST_OFF   = 5'h02;
  localparam [4:0] ST_ON    = 5'h04;
  localparam [4:0] ST_RX    = 5'h08;
  localparam [4:0] ST_TX    = 5'h10;
  // Sequencer phases, one-hot.
  localparam [6:0] PH_IDLE  = 7'h01;
  localparam [6:0] PH_DOWN  = 7'h02;
  localparam [6:0] PH_CHAN  = 7'h04;
  localparam [6:0] PH_CAL   = 7'h08;
  localparam [6:0] PH_SETL  = 7'h10;
  localparam [6:0] PH_UP    = 7'h20;
  localparam [6:0] PH_MEAS  = 7'h40;

  wire       byteValid;
  wire [7:0] cmdByte;
  wire       selected;
  wire       selFall;
  reg  [7:0] modeCtrl_reg;
  reg  [7:0] strength_reg;
  reg  [6:0] phase_reg;
  reg  [7:0] count_reg;
  reg  [4:0] target_reg;
  reg        skipCal_reg;
  reg        loadPrep_reg;
  reg        fwLoaded_reg;

  rsc_serial_rx u_rx (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .sclk      (sclk),
    .csN       (csN),
    .mosi      (mosi),
    .byteValid (byteValid),
    .byteData  (cmdByte),
    .selected  (selected),
    .selFall   (selFall)
  );

  // Readiness is shown on the data output while selected; tristated otherwise.
  assign misoOut = cmdReady;
  assign misoOeN = ~selected;

  always @* begin
    case (regAddr)
      `RSC_ADDR_MODE_CTRL: regRdata = modeCtrl_reg;
      `RSC_ADDR_STRENGTH:  regRdata = strength_reg;
      default:             regRdata = 8'h00;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeCtrl_reg       <= `RSC_MODE_RESET;
      strength_reg       <= 8'h00;
      phase_reg          <= PH_IDLE;
      count_reg          <= 8'h00;
      target_reg         <= ST_OFF;
      skipCal_reg        <= 1'b0;
      loadPrep_reg       <= 1'b0;
      fwLoaded_reg       <= 1'b0;
      recordedRadioState <= ST_OFF;
      cmdReady           <= 1'b1;
      powerOnResetFlag   <= 1'b1;
      rfRegulatorOn      <= 1'b0;
      synthOn            <= 1'b0;
      receiverOn         <= 1'b0;
      rxLogicOn          <= 1'b0;
      txLogicOn          <= 1'b0;
      paOn               <= 1'b0;
      extPaOn            <= 1'b0;
      extLnaOn           <= 1'b0;
      loopsLocked        <= 1'b0;
      channelFreq        <= 24'h000000;
      configPulse        <= 1'b0;
      calPulse           <= 1'b0;
      smartWakePulse     <= 1'b0;
      procResetPulse     <= 1'b0;
      packetClearPulse   <= 1'b0;
    end else begin
      configPulse      <= 1'b0;
      calPulse         <= 1'b0;
      smartWakePulse   <= 1'b0;
      procResetPulse   <= 1'b0;
      packetClearPulse <= 1'b0;
      if (regWrite && regAddr == `RSC_ADDR_MODE_CTRL) begin
        modeCtrl_reg <= regWdata;
      end
      if (count_reg != 8'h00) begin
        count_reg <= count_reg - 8'h01;
      end
      if (byteValid && cmdByte == `RSC_HARDWARE_RESET_COMMAND) begin
        recordedRadioState <= ST_SLEEP;
        phase_reg     <= PH_IDLE;
        count_reg     <= 8'h00;
        rfRegulatorOn <= 1'b0;
        synthOn       <= 1'b0;
        receiverOn    <= 1'b0;
        rxLogicOn     <= 1'b0;
        txLogicOn     <= 1'b0;
        paOn          <= 1'b0;
        extPaOn       <= 1'b0;
        extLnaOn      <= 1'b0;
        loopsLocked   <= 1'b0;
        cmdReady      <= 1'b0;
        fwLoaded_reg  <= 1'b0;
        loadPrep_reg  <= 1'b0;
      end else if (recordedRadioState == ST_SLEEP) begin
        if (selFall) begin
          recordedRadioState <= ST_OFF;
          cmdReady           <= 1'b1;
          powerOnResetFlag   <= 1'b0;
        end else if (wakeTimeout) begin
          if (smartWakeEn) begin
            smartWakePulse <= 1'b1;
          end else if (!fwTimerEn) begin
            recordedRadioState <= ST_OFF;
            cmdReady           <= 1'b1;
            powerOnResetFlag   <= 1'b0;
          end
        end
      end else if (phase_reg != PH_IDLE) begin
        if (count_reg == 8'h00) begin
          case (phase_reg)
            PH_DOWN: begin
              paOn <= 1'b0;
              extPaOn <= 1'b0;
              txLogicOn <= 1'b0;
              extLnaOn <= 1'b0;
              loopsLocked <= 1'b0;
              rxLogicOn <= 1'b0;
              if (target_reg == ST_ON) begin
                if (recordedRadioState == ST_RX) begin
                  strength_reg <= strengthMeas;
                end
                synthOn    <= 1'b0;
                receiverOn <= 1'b0;
                recordedRadioState <= ST_ON;
                phase_reg  <= PH_IDLE;
                cmdReady   <= 1'b1;
              end else begin
                receiverOn <= (target_reg == ST_RX);
                synthOn    <= 1'b1;
                phase_reg  <= PH_CHAN;
                count_reg  <= STEP[7:0];
              end
            end
            PH_CHAN: begin
              channelFreq <= channelFreqCfg;
              phase_reg   <= skipCal_reg ? PH_SETL : PH_CAL;
              count_reg   <= skipCal_reg ? SETTLE[7:0] : STEP[7:0];
            end
            PH_CAL: begin
              calPulse  <= 1'b1;
              phase_reg <= PH_SETL;
              count_reg <= SETTLE[7:0];
            end
            PH_SETL: begin
              phase_reg <= PH_UP;
              count_reg <= STEP[7:0];
            end
            PH_UP: begin
              if (target_reg == ST_RX) begin
                rxLogicOn   <= 1'b1;
                loopsLocked <= 1'b1;
                extLnaOn    <= modeCtrl_reg[`RSC_BIT_EXT_LNA];
              end else if (target_reg == ST_TX) begin
                txLogicOn <= 1'b1;
                extPaOn   <= modeCtrl_reg[`RSC_BIT_EXT_PA];
                paOn      <= 1'b1;
              end else begin
                calPulse  <= 1'b1;
              end
              recordedRadioState <= target_reg;
              phase_reg <= PH_IDLE;
              cmdReady  <= 1'b1;
            end
            PH_MEAS: begin
              strength_reg <= strengthMeas;
              receiverOn   <= 1'b0;
              phase_reg    <= PH_IDLE;
              cmdReady     <= 1'b1;
            end
            default: phase_reg <= PH_IDLE;
          endcase
        end
      end else if (byteValid) begin
        case (cmdByte)
          `RSC_CMD_GO_OFF: if (recordedRadioState == ST_ON) begin
            rfRegulatorOn      <= 1'b0;
            recordedRadioState <= ST_OFF;
          end
          `RSC_CMD_GO_ON: begin
            if (recordedRadioState == ST_OFF) begin
              rfRegulatorOn <= 1'b1;
              target_reg    <= ST_ON;
              if (modeCtrl_reg[`RSC_BIT_FILTER_CAL]) begin
                phase_reg <= PH_UP;
                count_reg <= STEP[7:0];
                cmdReady  <= 1'b0;
              end else begin
                recordedRadioState <= ST_ON;
              end
            end else if (recordedRadioState == ST_RX ||
                         recordedRadioState == ST_TX) begin
              target_reg <= ST_ON;
              phase_reg  <= PH_DOWN;
              count_reg  <= STEP[7:0];
              cmdReady   <= 1'b0;
            end
          end
          `RSC_CMD_GO_SLEEP:
            if (recordedRadioState == ST_OFF ||
                recordedRadioState == ST_ON) begin
              rfRegulatorOn      <= 1'b0;
              recordedRadioState <= ST_SLEEP;
              cmdReady           <= 1'b0;
            end
          `RSC_CMD_GO_RECEIVE, `RSC_CMD_GO_TRANSMIT:
            if (recordedRadioState == ST_ON ||
                recordedRadioState == ST_RX ||
                recordedRadioState == ST_TX) begin
              target_reg <= (cmdByte == `RSC_CMD_GO_RECEIVE) ? ST_RX : ST_TX;
              skipCal_reg <= (cmdByte == `RSC_CMD_GO_TRANSMIT) &&
                             (recordedRadioState == ST_RX);
              phase_reg  <= PH_DOWN;
              count_reg  <= STEP[7:0];
              cmdReady   <= 1'b0;
            end
          `RSC_CMD_CONFIGURE:
            if (recordedRadioState == ST_OFF ||
                recordedRadioState == ST_ON) begin
              configPulse <= 1'b1;
            end
          `RSC_CMD_MEASURE: if (recordedRadioState == ST_ON) begin
            receiverOn <= 1'b1;
            phase_reg  <= PH_MEAS;
            count_reg  <= SETTLE[7:0];
            cmdReady   <= 1'b0;
          end
          `RSC_CMD_FILTER_CAL: if (recordedRadioState == ST_ON) begin
            calPulse <= 1'b1;
          end
          `RSC_CMD_IMAGE_CAL:
            if (fwLoaded_reg && recordedRadioState == ST_ON) begin
              calPulse <= 1'b1;
            end
          `RSC_CMD_LOAD_PREP: loadPrep_reg <= 1'b1;
          `RSC_CMD_LOAD_DONE:
            if (recordedRadioState == ST_OFF && loadPrep_reg) begin
              procResetPulse   <= 1'b1;
              packetClearPulse <= 1'b1;
              fwLoaded_reg     <= 1'b1;
              loadPrep_reg     <= 1'b0;
            end
          default: loadPrep_reg <= loadPrep_reg;
        endcase
      end
    end
  end
endmodule // rsc_radio_ctrl

/* File: shared/rsc_defines.vh */
// Command codes, register addresses, field positions and timing counts.
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH
`define RSC_CMD_GO_OFF      8'hb0
`define RSC_CMD_GO_ON       8'hb1
`define RSC_CMD_GO_RECEIVE  8'hb2
`define RSC_CMD_GO_TRANSMIT 8'hb5
`define RSC_CMD_GO_SLEEP    8'hba
`define RSC_CMD_CONFIGURE   8'hbb
`define RSC_CMD_MEASURE     8'hbc
`define RSC_CMD_IMAGE_CAL   8'hbd
`define RSC_CMD_FILTER_CAL  8'hbe
`define RSC_CMD_LOAD_PREP   8'hbf
`define RSC_CMD_LOAD_DONE   8'hc7
`define RSC_HARDWARE_RESET_COMMAND    8'hc8
`define RSC_ADDR_MODE_CTRL  10'h11a
`define RSC_ADDR_STRENGTH   10'h312
`define RSC_MODE_RESET      8'h00
`define RSC_BIT_FILTER_CAL  3
`define RSC_BIT_EXT_PA      0
`define RSC_BIT_EXT_LNA     1
`define RSC_STEP_CYCLES     8'h08
`define RSC_SETTLE_CYCLES   8'h40
`endif

/* File: rtl/rsc_serial_rx.v */
// Serial command receiver: samples the link pins and assembles bytes.
`timescale 1ns/100ps
module rsc_serial_rx (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       sclk,
  input  wire       csN,
  input  wire       mosi,
  output reg        byteValid,
  output reg  [7:0] byteData,
  output reg        selected,
  output reg        selFall
);
  reg [2:0] sclkSync;
  reg [2:0] csSync;
  reg [2:0] mosiSync;
  reg [2:0] bitCount;
  reg [6:0] shiftReg;
  reg       sclkEdgeSeen;
  wire      sclkRise;
  wire      csLow;

  // A change counts once the second and third stages agree.
  assign sclkRise = sclkSync[1] & sclkSync[2] & ~sclkEdgeSeen;
  assign csLow    = ~csSync[1] & ~csSync[2];

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkSync  <= 3'h0;
      csSync    <= 3'h7;
      mosiSync  <= 3'h0;
      bitCount  <= 3'h0;
      shiftReg  <= 7'h00;
      byteValid <= 1'b0;
      byteData  <= 8'h00;
      selected  <= 1'b0;
      selFall   <= 1'b0;
    end else begin
      sclkSync  <= {sclkSync[1:0], sclk};
      csSync    <= {csSync[1:0], csN};
      mosiSync  <= {mosiSync[1:0], mosi};
      byteValid <= 1'b0;
      selFall   <= csLow & ~selected;
      if (csSync[1] == csSync[2]) begin
        selected <= ~csSync[2];
      end
      if (!selected) begin
        bitCount <= 3'h0;
      end else if (sclkRise) begin
        shiftReg <= {shiftReg[5:0], mosiSync[2]};
        bitCount <= bitCount + 3'h1;
        if (bitCount == 3'h7) begin
          byteValid <= 1'b1;
          byteData  <= {shiftReg, mosiSync[2]};
        end
      end
    end
  end

  // Remembers the agreed clock level so each rising edge counts once.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkEdgeSeen <= 1'b0;
    end else if (sclkSync[1] == sclkSync[2]) begin
      sclkEdgeSeen <= sclkSync[2];
    end
  end
endmodule // rsc_serial_rx

/* File: testbench/rsc_radio_ctrl_asserts.sv */
// Port-level assertions for the radio state controller.
`timescale 1ns/100ps
module rsc_radio_ctrl_asserts #(
  parameter STEP = 8,
  parameter SETTLE = 64
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        misoOut,
  input wire logic        misoOeN,
  input wire logic        cmdReady,
  input wire logic [4:0]  recordedRadioState,
  input wire logic        rfRegulatorOn,
  input wire logic        synthOn,
  input wire logic        receiverOn,
  input wire logic        rxLogicOn,
  input wire logic        txLogicOn,
  input wire logic        paOn,
  input wire logic        extPaOn,
  input wire logic        extLnaOn,
  input wire logic        loopsLocked,
  input wire logic [23:0] channelFreq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence sTxStop;
    ##[0:40] (!extPaOn && !txLogicOn);
  endsequence
  a_miso_ready: assert property (!misoOeN && $stable(cmdReady) |->
    misoOut == cmdReady) else $error("miso differs from ready");
  a_on_quiet: assert property (recordedRadioState == 5'h04 && cmdReady |->
    rfRegulatorOn && !synthOn && !receiverOn && !paOn && !extLnaOn)
    else $error("on state not quiet");
  a_off_dark: assert property (recordedRadioState == 5'h02 && cmdReady |->
    !rfRegulatorOn && !synthOn && !paOn) else $error("off state powered");
  a_rx_ready: assert property (recordedRadioState == 5'h08 && cmdReady |->
    synthOn && receiverOn && rxLogicOn && loopsLocked && !paOn)
    else $error("receive state incomplete");
  a_tx_ready: assert property (recordedRadioState == 5'h10 && cmdReady |->
    synthOn && txLogicOn && paOn && !receiverOn)
    else $error("transmit state incomplete");
  a_pa_down_first: assert property ($fell(paOn) |-> sTxStop)
    else $error("transmit not stopped after ramp down");
  a_lna_drop_first: assert property ($fell(rxLogicOn) |-> !extLnaOn)
    else $error("lna still on after receive stop");
  a_chan_in_setup: assert property ($changed(channelFreq) |->
    synthOn && !cmdReady) else $error("channel changed outside setup");
endmodule // rsc_radio_ctrl_asserts
bind rsc_radio_ctrl rsc_radio_ctrl_asserts #(.STEP(STEP), .SETTLE(SETTLE))
  uChk (.ref_clk(ref_clk), .rst_n(rst_n), .misoOut(misoOut),
  .misoOeN(misoOeN), .cmdReady(cmdReady),
  .recordedRadioState(recordedRadioState), .rfRegulatorOn(rfRegulatorOn),
  .synthOn(synthOn), .receiverOn(receiverOn), .rxLogicOn(rxLogicOn),
  .txLogicOn(txLogicOn), .paOn(paOn), .extPaOn(extPaOn),
  .extLnaOn(extLnaOn), .loopsLocked(loopsLocked),
  .channelFreq(channelFreq));

/* File: testbench/rsc_host_model.sv */
// Host model that drives the serial command link.
`timescale 1ns/100ps
module rsc_host_model (
  input  wire logic refClk,
  input  wire logic misoOut,
  input  wire logic misoOeN,
  output logic      sclk,
  output logic      csN,
  output logic      mosi
);
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    mosi = 1'b1;
  end
  task automatic halfBit;
    repeat (6) @(negedge refClk);
  endtask
  task automatic sendByte(input logic [7:0] b);
    integer i;
    halfBit();
    csN = 1'b0;
    for (i = 7; i >= 0; i = i - 1) begin
      mosi = b[i];
      halfBit();
      sclk = 1'b1;
      halfBit();
      sclk = 1'b0;
    end
    halfBit();
    csN = 1'b1;
    // A released line flips so a stale bit never reads as data.
    mosi = ~mosi;
  endtask
  task automatic wakeByCs;
    integer i;
    csN = 1'b0;
    for (i = 0; i < 2000 && !(misoOeN === 1'b0 && misoOut === 1'b1);
         i = i + 1)
      @(negedge refClk);
    halfBit();
    csN = 1'b1;
  endtask
endmodule // rsc_host_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the radio state controller.
`timescale 1ns/100ps
`include "rsc_defines.vh"
module tb_top;
  logic        refClk;
  logic        rstN;
  logic        wakeTimeout;
  logic        smartWakeEn;
  logic        fwTimerEn;
  logic        regWrite;
  logic [9:0]  regAddr;
  logic [7:0]  regWdata;
  logic [7:0]  strengthMeas;
  logic [23:0] channelFreqCfg;
  wire         sclk, csN, mosi, misoOut, misoOeN, cmdReady, loopsLocked;
  wire         powerOnResetFlag, rfRegulatorOn, synthOn, receiverOn;
  wire         rxLogicOn, txLogicOn, paOn, extPaOn, extLnaOn;
  wire         configPulse, calPulse, smartWakePulse;
  wire         procResetPulse, packetClearPulse;
  wire [7:0]   regRdata;
  wire [4:0]   recordedRadioState;
  wire [23:0]  channelFreq;
  wire [7:0]   pw = {rfRegulatorOn, synthOn, receiverOn, rxLogicOn,
                     txLogicOn, paOn, extPaOn, extLnaOn};
  integer      failCount = 0;
  integer      nChecks = 0;
  integer      calCnt, cfgCnt, swCnt, ldCnt;
  logic        clrCnt;

  // A long settle keeps a sequence busy while a second byte arrives.
  rsc_radio_ctrl #(.STEP(8), .SETTLE(200)) dut (
    .ref_clk(refClk), .rst_n(rstN), .sclk(sclk), .csN(csN), .mosi(mosi),
    .misoOut(misoOut), .misoOeN(misoOeN), .wakeTimeout(wakeTimeout),
    .smartWakeEn(smartWakeEn), .fwTimerEn(fwTimerEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRdata(regRdata),
    .strengthMeas(strengthMeas), .channelFreqCfg(channelFreqCfg),
    .recordedRadioState(recordedRadioState), .cmdReady(cmdReady),
    .powerOnResetFlag(powerOnResetFlag), .rfRegulatorOn(rfRegulatorOn),
    .synthOn(synthOn), .receiverOn(receiverOn), .rxLogicOn(rxLogicOn),
    .txLogicOn(txLogicOn), .paOn(paOn), .extPaOn(extPaOn),
    .extLnaOn(extLnaOn), .loopsLocked(loopsLocked),
    .channelFreq(channelFreq), .configPulse(configPulse),
    .calPulse(calPulse), .smartWakePulse(smartWakePulse),
    .procResetPulse(procResetPulse), .packetClearPulse(packetClearPulse));
  rsc_host_model host (.refClk(refClk), .misoOut(misoOut),
    .misoOeN(misoOeN), .sclk(sclk), .csN(csN), .mosi(mosi));

  // Pulse counters have one driver; a command clears them through clrCnt.
  always @(posedge refClk) begin
    if (clrCnt) begin
      calCnt <= 0;
      cfgCnt <= 0;
      swCnt <= 0;
      ldCnt <= 0;
    end else begin
      calCnt <= calCnt + calPulse;
      cfgCnt <= cfgCnt + configPulse;
      swCnt <= swCnt + smartWakePulse;
      ldCnt <= ldCnt + procResetPulse + packetClearPulse;
    end
  end
  task automatic finishTest;
    if (failCount == 0 && nChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks = nChecks + 1;
    if (seen !== exp) begin
      failCount = failCount + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic waitReady;
    integer i;
    repeat (12) @(negedge refClk);
    for (i = 0; i < 1000 && cmdReady !== 1'b1; i = i + 1)
      @(negedge refClk);
  endtask
  task automatic cmd(input logic [7:0] code);
    clrCnt = 1'b1;
    @(negedge refClk);
    clrCnt = 1'b0;
    host.sendByte(code);
    waitReady();
  endtask
  task automatic regWr(input logic [9:0] a, input logic [7:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge refClk);
    regWrite = 1'b0;
    @(negedge refClk);
  endtask
  task automatic regChk(input logic [9:0] a, input logic [7:0] exp);
    regAddr = a;
    #1 check(regRdata, exp);
  endtask
  task automatic wake(input logic smart);
    smartWakeEn = smart;
    wakeTimeout = 1'b1;
    @(negedge refClk);
    wakeTimeout = 1'b0;
    waitReady();
  endtask

  initial begin
    refClk = 1'b0;
    forever #2 refClk = ~refClk;
  end
  initial begin
    #200000;
    failCount = failCount + 1;
    finishTest();
  end
  initial begin
    rstN = 1'b0;
    clrCnt = 1'b1;
    regAddr = 10'h000;
    regWdata = 8'h00;
    regWrite = 1'b0;
    wakeTimeout = 1'b0;
    smartWakeEn = 1'b0;
    fwTimerEn = 1'b0;
    strengthMeas = 8'h3c;
    channelFreqCfg = 24'h123456;
    repeat (6) @(negedge refClk);
    rstN = 1'b1;
    repeat (6) @(negedge refClk);
    check(powerOnResetFlag, 1'b1);
    regChk(`RSC_ADDR_MODE_CTRL, `RSC_MODE_RESET);
    regChk(10'h100, 8'h00);
    regWr(`RSC_ADDR_STRENGTH, 8'hff);
    regChk(`RSC_ADDR_STRENGTH, 8'h00);
    regWr(`RSC_ADDR_MODE_CTRL, 8'h0b);
    regChk(`RSC_ADDR_MODE_CTRL, 8'h0b);
    cmd(`RSC_CMD_GO_OFF);
    check(recordedRadioState, 5'h02);
    cmd(`RSC_CMD_FILTER_CAL);
    check(calCnt, 0);
    cmd(`RSC_CMD_GO_ON);
    check({recordedRadioState, pw}, {5'h04, 8'h80});
    check(calCnt, 1);
    cmd(`RSC_CMD_CONFIGURE);
    check({cfgCnt[7:0], channelFreq}, {8'h01, 24'h000000});
    cmd(`RSC_CMD_GO_RECEIVE);
    check({recordedRadioState, pw}, {5'h08, 8'hf1});
    check({calCnt[7:0], channelFreq}, {8'h01, 24'h123456});
    channelFreqCfg = 24'h0abcde;
    cmd(`RSC_CMD_GO_RECEIVE);
    check({calCnt[7:0], channelFreq}, {8'h01, 24'h0abcde});
    cmd(`RSC_CMD_GO_TRANSMIT);
    check({recordedRadioState, pw}, {5'h10, 8'hce});
    check(calCnt, 0);
    cmd(`RSC_CMD_GO_TRANSMIT);
    check({recordedRadioState, calCnt[7:0]}, {5'h10, 8'h01});
    cmd(`RSC_CMD_GO_RECEIVE);
    check({recordedRadioState, pw}, {5'h08, 8'hf1});
    cmd(`RSC_CMD_GO_ON);
    check({recordedRadioState, pw}, {5'h04, 8'h80});
    regChk(`RSC_ADDR_STRENGTH, 8'h3c);
    cmd(`RSC_CMD_GO_TRANSMIT);
    check(recordedRadioState, 5'h10);
    cmd(`RSC_CMD_GO_ON);
    check({recordedRadioState, pw}, {5'h04, 8'h80});
    strengthMeas = 8'ha5;
    cmd(`RSC_CMD_MEASURE);
    check(recordedRadioState, 5'h04);
    regChk(`RSC_ADDR_STRENGTH, 8'ha5);
    cmd(`RSC_CMD_FILTER_CAL);
    check(calCnt, 1);
    cmd(`RSC_CMD_GO_OFF);
    check({recordedRadioState, pw}, {5'h02, 8'h00});
    cmd(`RSC_CMD_LOAD_PREP);
    cmd(`RSC_CMD_LOAD_DONE);
    check({recordedRadioState, ldCnt[7:0]}, {5'h02, 8'h02});
    regWr(`RSC_ADDR_MODE_CTRL, 8'h03);
    cmd(`RSC_CMD_GO_ON);
    check({recordedRadioState, calCnt[7:0]}, {5'h04, 8'h00});
    cmd(`RSC_CMD_GO_SLEEP);
    check(recordedRadioState, 5'h01);
    host.wakeByCs();
    waitReady();
    check({recordedRadioState, powerOnResetFlag}, {5'h02, 1'b0});
    cmd(`RSC_CMD_GO_SLEEP);
    check(recordedRadioState, 5'h01);
    wake(1'b0);
    check(recordedRadioState, 5'h02);
    cmd(`RSC_CMD_GO_SLEEP);
    wake(1'b1);
    check(swCnt, 1);
    smartWakeEn = 1'b0;
    cmd(`RSC_HARDWARE_RESET_COMMAND);
    check({recordedRadioState, pw}, {5'h01, 8'h00});
    host.wakeByCs();
    waitReady();
    cmd(`RSC_CMD_GO_ON);
    cmd(`RSC_CMD_IMAGE_CAL);
    check(recordedRadioState, 5'h04);
    check(calCnt, 0);
    host.sendByte(`RSC_CMD_GO_RECEIVE);
    host.sendByte(`RSC_HARDWARE_RESET_COMMAND);
    waitReady();
    check({recordedRadioState, pw}, {5'h01, 8'h00});
    finishTest();
  end
endmodule // tb_top
